// [pkg/ufcb_pkg.sv]
// Summary of operation
// [RL1] Bridge drives clear-to-send out to target; target drives request-to-send in.
// [RL2] With outbound throttling, clear-to-send drops while receive buffer is full.
// [RL3] Target pauses its transmitter while clear-to-send is deasserted.
// [RL4] With inbound gating, bridge stops sending while request-to-send is deasserted.
// [RL5] Request-to-send drop never cuts short the character being shifted out.
// [RL6] Target accepts at least one more character after dropping request-to-send.
// [RL7] Handshake off: clear-to-send undriven, request-to-send ignored.
// [RL8] Outbound-only: drive clear-to-send on full buffer, ignore request-to-send.
// [RL9] Inbound-only: clear-to-send undriven, send only while request-to-send asserted.
// [RL10] Bidirectional: drive clear-to-send on full, gate sending on request-to-send.
// [RL11] Target must drive request-to-send when inbound gating is on.
// [RL12] Default link 115200 baud, 8N1, flow control off.
// [RL13] Bit rate configurable from 9600 to 921600 bits per second.
// [RL14] Separate enable gates all data between target and bridge.
// [RL15] Clear-to-send reasserts once receive buffer space is available again.
`default_nettype none
package ufcb_pkg;

  typedef enum logic [1:0] {
    UFCB_HS_OFF,
    UFCB_HS_OUT,
    UFCB_HS_IN,
    UFCB_HS_BOTH
  } ufcb_hs_e;

  localparam int unsigned CLK_HZ        = 200_000_000;
  localparam int unsigned BAUD_DEFAULT  = 115_200;
  localparam int unsigned BAUD_MIN      = 9_600;
  localparam int unsigned BAUD_MAX      = 921_600;
  // Divider counts clock cycles per bit
  localparam logic [15:0] DIV_DEFAULT   = 16'(CLK_HZ / BAUD_DEFAULT);
  localparam logic [15:0] DIV_MAX       = 16'(CLK_HZ / BAUD_MIN);
  localparam logic [15:0] DIV_MIN       = 16'(CLK_HZ / BAUD_MAX);
  localparam int unsigned DATA_BITS     = 8;
  localparam int unsigned FIFO_DEPTH    = 8;

  // Register byte addresses
  localparam logic [11:0] ADDR_CTRL     = 12'h000;
  localparam logic [11:0] ADDR_BAUD     = 12'h004;
  localparam logic [11:0] ADDR_STATUS   = 12'h008;
  localparam logic [11:0] ADDR_TXDATA   = 12'h00C;
  localparam logic [11:0] ADDR_RXDATA   = 12'h010;

  // CTRL fields
  localparam int unsigned CTRL_EN_BIT   = 0;
  localparam int unsigned CTRL_HS_LSB   = 1;
  localparam logic [2:0]  CTRL_RESET    = 3'h0;

  // STATUS fields
  localparam int unsigned ST_RXVALID    = 0;
  localparam int unsigned ST_RXFULL     = 1;
  localparam int unsigned ST_TXFULL     = 2;
  localparam int unsigned ST_TXBUSY     = 3;
  localparam int unsigned ST_CTS        = 4;
  localparam int unsigned ST_RTS        = 5;
  localparam int unsigned ST_FRAMEERR   = 6;

endpackage : ufcb_pkg
`default_nettype wire

// [hdl/ufcb_fifo.sv]
`timescale 1ns/10ps
`default_nettype none
module ufcb_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 8
) (
  // Clock and reset
  input  wire logic             pclk,
  input  wire logic             presetn,
  // Fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data,
  // Status
  output logic                  full
);
  localparam int unsigned AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_q;
  logic [AW-1:0]    rd_q;
  logic [AW:0]      cnt_q;
  logic             push;
  logic             pop;

  assign full      = (cnt_q == (AW+1)'(DEPTH));
  assign in_ready  = !full;
  assign out_valid = (cnt_q != '0);
  assign out_data  = mem[rd_q];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_ff @(posedge pclk) begin
    if (push) begin
      mem[wr_q] <= in_data;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
      end
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : ufcb_fifo
`default_nettype wire

// [hdl/ufcb_baud.sv]
`timescale 1ns/10ps
`default_nettype none
module ufcb_baud (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // Control
  input  wire logic        restart,
  input  wire logic [15:0] div,
  // Bit-rate tick
  output logic             tick,
  output logic             half
);
  logic [15:0] cnt_q;

  // Mid-bit pulse lets the receiver sample at bit centre
  assign tick = (cnt_q == div - 16'h0001);
  assign half = (cnt_q == {1'b0, div[15:1]});

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= '0;
    end else if (restart || tick) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_q + 16'h0001;
    end
  end
endmodule : ufcb_baud
`default_nettype wire

// [hdl/ufcb_bridge.sv]
// Decided for this implementation: register access over APB and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
module ufcb_bridge (
  // APB
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Serial link to target
  output logic             txd,
  input  wire logic        rxd,
  output logic             cts_o,
  output logic             cts_oe,
  input  wire logic        rts_i,
  // Interface enable
  input  wire logic        link_enable
);
  typedef enum logic [1:0] {
    UFCB_TX_IDLE,
    UFCB_TX_START,
    UFCB_TX_DATA,
    UFCB_TX_STOP
  } ufcb_tx_e;

  typedef enum logic [1:0] {
    UFCB_RX_IDLE,
    UFCB_RX_START,
    UFCB_RX_DATA,
    UFCB_RX_STOP
  } ufcb_rx_e;

  // Registers
  logic                 en_q;
  ufcb_pkg::ufcb_hs_e   hs_q;
  logic [15:0]          div_q;
  logic                 ferr_q;

  // APB decode
  logic access;
  logic wr_fire;
  logic rd_fire;
  logic rd_setup;
  logic wr_ctrl;
  logic wr_baud;
  logic wr_tx;
  logic wr_stat;
  logic rd_rxd;

  assign pready   = 1'b1;
  assign access   = psel && penable;
  assign wr_fire  = access && pwrite;
  assign rd_fire  = access && !pwrite;
  assign rd_setup = psel && !penable && !pwrite;

  // CTRL and TXDATA writes need byte lane 0, BAUD writes lanes 0 and 1; a STATUS write ignores pstrb
  assign wr_ctrl = wr_fire && (paddr == ufcb_pkg::ADDR_CTRL) && pstrb[0];
  assign wr_baud = wr_fire && (paddr == ufcb_pkg::ADDR_BAUD) && (pstrb[1:0] == 2'b11);
  assign wr_tx   = wr_fire && (paddr == ufcb_pkg::ADDR_TXDATA) && pstrb[0];
  assign wr_stat = wr_fire && (paddr == ufcb_pkg::ADDR_STATUS);
  assign rd_rxd  = rd_fire && (paddr == ufcb_pkg::ADDR_RXDATA);

  function automatic logic addr_known(input logic [11:0] a);
    addr_known = (a == ufcb_pkg::ADDR_CTRL)   || (a == ufcb_pkg::ADDR_BAUD) ||
                 (a == ufcb_pkg::ADDR_STATUS) || (a == ufcb_pkg::ADDR_TXDATA) ||
                 (a == ufcb_pkg::ADDR_RXDATA);
  endfunction : addr_known

  // Unmapped or refused access answers with an error
  logic tx_in_ready;
  logic txw_err;
  assign txw_err = (paddr == ufcb_pkg::ADDR_TXDATA) && pwrite && !tx_in_ready;
  assign pslverr = access && (!addr_known(paddr) || txw_err);

  // Mode and enable
  logic go;
  logic gate_out;
  logic gate_in;
  assign go       = en_q && link_enable;                                        // RL14
  assign gate_out = (hs_q == ufcb_pkg::UFCB_HS_OUT) || (hs_q == ufcb_pkg::UFCB_HS_BOTH);
  assign gate_in  = (hs_q == ufcb_pkg::UFCB_HS_IN) || (hs_q == ufcb_pkg::UFCB_HS_BOTH);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_q <= ufcb_pkg::CTRL_RESET[ufcb_pkg::CTRL_EN_BIT];
      hs_q <= ufcb_pkg::UFCB_HS_OFF;                                           // RL12
    end else if (wr_ctrl) begin
      en_q <= pwdata[ufcb_pkg::CTRL_EN_BIT];
      hs_q <= ufcb_pkg::ufcb_hs_e'(pwdata[ufcb_pkg::CTRL_HS_LSB +: 2]);
    end
  end

  // Divider clamped to the supported bit-rate range
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_q <= ufcb_pkg::DIV_DEFAULT;                                          // RL12
    end else if (wr_baud) begin
      if (pwdata[15:0] < ufcb_pkg::DIV_MIN) begin
        div_q <= ufcb_pkg::DIV_MIN;                                            // RL13
      end else if (pwdata[15:0] > ufcb_pkg::DIV_MAX) begin
        div_q <= ufcb_pkg::DIV_MAX;                                            // RL13
      end else begin
        div_q <= pwdata[15:0];
      end
    end
  end

  // Host-to-target buffer
  logic       tx_out_valid;
  logic       tx_out_ready;
  logic [7:0] tx_out_data;
  logic       tx_full;

  ufcb_fifo #(.WIDTH(ufcb_pkg::DATA_BITS), .DEPTH(ufcb_pkg::FIFO_DEPTH)) u_txf (
    .pclk      (pclk),
    .presetn   (presetn),
    .in_valid  (wr_tx),
    .in_ready  (tx_in_ready),
    .in_data   (pwdata[7:0]),
    .out_valid (tx_out_valid),
    .out_ready (tx_out_ready),
    .out_data  (tx_out_data),
    .full      (tx_full)
  );

  // Target-to-host buffer
  logic       rx_in_valid;
  logic       rx_in_ready;
  logic [7:0] rx_in_data;
  logic       rx_out_valid;
  logic [7:0] rx_out_data;
  logic       rx_full;
  logic       rx_seen_q;

  // Pop only a word already there when read data was latched
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_seen_q <= 1'b0;
    end else begin
      rx_seen_q <= rd_setup && rx_out_valid;
    end
  end

  ufcb_fifo #(.WIDTH(ufcb_pkg::DATA_BITS), .DEPTH(ufcb_pkg::FIFO_DEPTH)) u_rxf (
    .pclk      (pclk),
    .presetn   (presetn),
    .in_valid  (rx_in_valid),
    .in_ready  (rx_in_ready),
    .in_data   (rx_in_data),
    .out_valid (rx_out_valid),
    .out_ready (rd_rxd && rx_seen_q),
    .out_data  (rx_out_data),
    .full      (rx_full)
  );

  // Clear-to-send: driven only in modes that throttle the target
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cts_o  <= 1'b0;
      cts_oe <= 1'b0;
    end else begin
      cts_oe <= gate_out;                                                      // RL1 RL7 RL9
      cts_o  <= gate_out && !rx_full;                                          // RL2 RL8 RL10 RL15
    end
  end

  // Transmitter
  ufcb_tx_e   tx_st_q;
  logic [7:0] tx_sh_q;
  logic [2:0] tx_bit_q;
  logic       tx_tick;
  logic       tx_start;

  // Request-to-send checked only between characters
  assign tx_start     = (tx_st_q == UFCB_TX_IDLE) && tx_out_valid && go &&
                        (!gate_in || rts_i);                                   // RL4 RL7 RL8 RL9 RL10
  assign tx_out_ready = tx_start;

  ufcb_baud u_txb (
    .pclk    (pclk),
    .presetn (presetn),
    .restart (tx_start),
    .div     (div_q),
    .tick    (tx_tick),
    .half    ()
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_st_q  <= UFCB_TX_IDLE;
      tx_sh_q  <= '0;
      tx_bit_q <= '0;
      txd      <= 1'b1;
    end else begin
      unique case (tx_st_q)
        UFCB_TX_IDLE: begin
          txd <= 1'b1;
          if (tx_start) begin
            tx_sh_q <= tx_out_data;
            txd     <= 1'b0;
            tx_st_q <= UFCB_TX_START;
          end
        end
        UFCB_TX_START: begin
          if (tx_tick) begin
            txd      <= tx_sh_q[0];
            tx_sh_q  <= {1'b0, tx_sh_q[7:1]};
            tx_bit_q <= '0;
            tx_st_q  <= UFCB_TX_DATA;
          end
        end
        UFCB_TX_DATA: begin
          // Runs to the end whatever request-to-send does
          if (tx_tick) begin                                                   // RL5
            if (tx_bit_q == 3'h7) begin
              txd     <= 1'b1;
              tx_st_q <= UFCB_TX_STOP;
            end else begin
              txd      <= tx_sh_q[0];
              tx_sh_q  <= {1'b0, tx_sh_q[7:1]};
              tx_bit_q <= tx_bit_q + 3'h1;
            end
          end
        end
        UFCB_TX_STOP: begin
          if (tx_tick) begin
            tx_st_q <= UFCB_TX_IDLE;
          end
        end
      endcase
    end
  end

  // Receiver
  ufcb_rx_e   rx_st_q;
  logic [7:0] rx_sh_q;
  logic [2:0] rx_bit_q;
  logic       rx_half;
  logic       rx_tick;
  logic       rx_begin;

  assign rx_begin = (rx_st_q == UFCB_RX_IDLE) && !rxd && go;                   // RL14

  ufcb_baud u_rxb (
    .pclk    (pclk),
    .presetn (presetn),
    .restart (rx_begin),
    .div     (div_q),
    .tick    (rx_tick),
    .half    (rx_half)
  );

  // Byte offered when stop bit centre seen; lost if buffer still full
  assign rx_in_valid = (rx_st_q == UFCB_RX_STOP) && rx_half && rxd;
  assign rx_in_data  = rx_sh_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_st_q  <= UFCB_RX_IDLE;
      rx_sh_q  <= '0;
      rx_bit_q <= '0;
    end else begin
      unique case (rx_st_q)
        UFCB_RX_IDLE: begin
          if (rx_begin) begin
            rx_st_q <= UFCB_RX_START;
          end
        end
        UFCB_RX_START: begin
          if (rx_half) begin
            rx_st_q <= rxd ? UFCB_RX_IDLE : UFCB_RX_DATA;
          end
        end
        UFCB_RX_DATA: begin
          if (rx_half) begin
            rx_sh_q <= {rxd, rx_sh_q[7:1]};
            if (rx_bit_q == 3'h7) begin
              rx_bit_q <= '0;
              rx_st_q  <= UFCB_RX_STOP;
            end else begin
              rx_bit_q <= rx_bit_q + 3'h1;
            end
          end
        end
        UFCB_RX_STOP: begin
          if (rx_half) begin
            rx_st_q <= UFCB_RX_IDLE;
          end
        end
      endcase
    end
  end

  // Framing error and overrun are sticky; new event wins over a clear
  logic rx_bad;
  assign rx_bad = (rx_st_q == UFCB_RX_STOP) && rx_half && (!rxd || !rx_in_ready);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ferr_q <= 1'b0;
    end else if (rx_bad) begin
      ferr_q <= 1'b1;
    end else if (wr_stat && pwdata[ufcb_pkg::ST_FRAMEERR]) begin
      ferr_q <= 1'b0;
    end
  end

  // Read mux
  logic [31:0] status;
  always_comb begin
    status = '0;
    status[ufcb_pkg::ST_RXVALID]  = rx_out_valid;
    status[ufcb_pkg::ST_RXFULL]   = rx_full;
    status[ufcb_pkg::ST_TXFULL]   = tx_full;
    status[ufcb_pkg::ST_TXBUSY]   = (tx_st_q != UFCB_TX_IDLE) || tx_out_valid;
    status[ufcb_pkg::ST_CTS]      = cts_o;
    status[ufcb_pkg::ST_RTS]      = rts_i;
    status[ufcb_pkg::ST_FRAMEERR] = ferr_q;
  end

  // Word picked in setup cycle so read data leaves a flop with no wait state
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = '0;
    unique case (paddr)
      ufcb_pkg::ADDR_CTRL:   rd_mux = {29'h0, hs_q, en_q};
      ufcb_pkg::ADDR_BAUD:   rd_mux = {16'h0, div_q};
      ufcb_pkg::ADDR_STATUS: rd_mux = status;
      ufcb_pkg::ADDR_RXDATA: rd_mux = {24'h0, rx_out_data};
      default:               rd_mux = '0;
    endcase
  end

  // Zero outside the access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
    end else begin
      prdata <= rd_setup ? rd_mux : 32'h0;
    end
  end
endmodule : ufcb_bridge
`default_nettype wire

// [sim/ufcb_bridge_monitor.sv]
`timescale 1ns/10ps
`default_nettype none
module ufcb_bridge_monitor (
  // APB
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  pstrb,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Serial link
  input wire logic        txd,
  input wire logic        rxd,
  input wire logic        cts_o,
  input wire logic        cts_oe,
  input wire logic        rts_i,
  input wire logic        link_enable
);
  logic [1:0]  hs_q;
  logic        en_q;
  logic [2:0]  since_q;
  logic [15:0] baud_q;
  logic [3:0]  rts_lo_q;
  logic [3:0]  lk_lo_q;
  logic [17:0] fcnt_q;
  logic        acc;
  logic        rd_rx;
  logic        sob;
  assign acc   = psel && penable;
  assign rd_rx = acc && !pwrite && paddr == ufcb_pkg::ADDR_RXDATA;
  assign sob   = fcnt_q == 18'h0 && !txd;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {hs_q, en_q} <= 3'h0;
      since_q      <= 3'h7;
    end else if (acc && pwrite && paddr == ufcb_pkg::ADDR_CTRL) begin
      {hs_q, en_q} <= pwdata[2:0];
      since_q      <= 3'h0;
    end else if (since_q != 3'h7) begin
      since_q <= since_q + 3'h1;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      baud_q <= ufcb_pkg::DIV_DEFAULT;
    end else if (acc && pwrite && paddr == ufcb_pkg::ADDR_BAUD) begin
      baud_q <= pwdata[15:0];
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rts_lo_q <= 4'h0;
      lk_lo_q  <= 4'h0;
    end else begin
      rts_lo_q <= rts_i ? 4'h0 : rts_lo_q + {3'h0, rts_lo_q != 4'hF};
      lk_lo_q  <= link_enable ? 4'h0 : lk_lo_q + {3'h0, lk_lo_q != 4'hF};
    end
  end
  // Timer ends mid stop bit, so a data-bit edge is never taken for a start
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fcnt_q <= 18'h0;
    end else if (fcnt_q != 18'h0) begin
      fcnt_q <= fcnt_q - 18'h1;
    end else if (!txd) begin
      fcnt_q <= 18'(baud_q) * 18'h9 + 18'(baud_q >> 1);
    end
  end

  AST_OE_MODE: assert property (since_q > 3'h2 |-> cts_oe == hs_q[0])
    else $error("cts drive does not follow mode");
  AST_CTS_UNDRIVEN: assert property (!cts_oe |-> !cts_o)
    else $error("cts high while undriven");
  AST_RTS_GATE: assert property (sob && hs_q[1] && since_q > 3'h2 |-> rts_lo_q < 4'h8)
    else $error("character started while rts low");
  AST_EN_GATE: assert property (sob |-> en_q && lk_lo_q < 4'h8)
    else $error("character started while disabled");
  AST_START_BIT: assert property (sob |=> !txd [*8])
    else $error("start bit too short");
  AST_STOP_BIT: assert property (fcnt_q != 18'h0 && fcnt_q <= 18'(baud_q >> 1) |-> txd)
    else $error("stop bit missing");
  AST_CTS_RESUME: assert property ($rose(cts_o) && $past(cts_oe) |-> $past(rd_rx, 2) || $past(rd_rx, 3))
    else $error("cts rose without a pop");
  AST_PRDATA_IDLE: assert property (!acc |-> prdata == 32'h0)
    else $error("read data outside access");
  cover property (sob && hs_q[1]);
  cover property ($fell(cts_o) && cts_oe);
  cover property (fcnt_q != 18'h0 && !rts_i && hs_q[1]);
endmodule : ufcb_bridge_monitor
`default_nettype wire

// [sim/ufcb_target_model.sv]
`timescale 1ns/10ps
`default_nettype none
module ufcb_target_model #(
  parameter int DIV = 217
) (
  // Link
  input  wire logic       pclk,
  input  wire logic       txd,
  input  wire logic       cts_o,
  input  wire logic       cts_oe,
  output logic            rxd,
  output logic            rts_i,
  // Bench side
  input  wire logic       rts_en,
  output logic            got_v,
  output logic [7:0]      got_d
);
  initial begin
    rxd   = 1'b1;
    got_v = 1'b0;
    got_d = 8'h00;
  end
  assign rts_i = rts_en;

  // Keeps taking characters even after rts is dropped
  always begin : rx_side
    @(negedge txd);
    repeat (DIV / 2) @(posedge pclk);
    for (int i = 0; i < 8; i++) begin
      repeat (DIV) @(posedge pclk);
      got_d[i] <= txd;
    end
    repeat (DIV) @(posedge pclk);
    got_v <= txd;
    @(posedge pclk);
    got_v <= 1'b0;
  end

  task automatic send(input logic [7:0] b, input int gap);
    repeat (gap) @(posedge pclk);
    while (cts_oe === 1'b1 && cts_o !== 1'b1) @(posedge pclk);
    @(posedge pclk);
    rxd <= 1'b0;
    repeat (DIV) @(posedge pclk);
    for (int k = 0; k < 8; k++) begin
      rxd <= b[k];
      repeat (DIV) @(posedge pclk);
    end
    rxd <= 1'b1;
    repeat (DIV) @(posedge pclk);
  endtask : send
endmodule : ufcb_target_model
`default_nettype wire

// [sim/ufcb_bridge_tb_top.sv]
`timescale 1ns/10ps
`default_nettype none
module ufcb_bridge_tb_top;
  localparam int CH = 10 * int'(ufcb_pkg::DIV_MIN);
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [3:0]  pstrb;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        txd;
  logic        rxd;
  logic        cts_o;
  logic        cts_oe;
  logic        rts_i;
  logic        link_enable;
  logic        rts_en;
  logic        got_v;
  logic [7:0]  got_d;
  logic [31:0] rd;
  logic        er;
  logic [31:0] seed = 32'h418C5F45;
  logic [7:0]  txq[$];
  logic [7:0]  rxq[$];
  int          n_fail = 0;
  int          num_checks = 0;
  int          n_got = 0;
  int          base;

  ufcb_bridge i_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .txd(txd), .rxd(rxd), .cts_o(cts_o), .cts_oe(cts_oe),
    .rts_i(rts_i), .link_enable(link_enable)
  );
  ufcb_target_model #(.DIV(int'(ufcb_pkg::DIV_MIN))) i_tgt (
    .pclk(pclk), .txd(txd), .cts_o(cts_o), .cts_oe(cts_oe), .rxd(rxd),
    .rts_i(rts_i), .rts_en(rts_en), .got_v(got_v), .got_d(got_d)
  );

  function automatic logic [7:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed[7:0];
  endfunction : rnd

  task automatic check(input logic ok, input string m);
    num_checks++;
    if (ok !== 1'b1) begin
      n_fail++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask : check

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic put(input logic [7:0] b, input logic ok);
    apb(1'b1, ufcb_pkg::ADDR_TXDATA, {24'h0, b});
    check(er === !ok, "write refusal wrong");
    if (ok) txq.push_back(b);
  endtask : put

  task automatic wait_got(input int n);
    for (int k = 0; k < 10 * CH && n_got < n; k++) @(posedge pclk);
    check(n_got == n, "bytes not delivered");
  endtask : wait_got

  task automatic results();
    $display("checks %0d failures %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : results

  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  initial begin
    repeat (95000) @(posedge pclk);
    n_fail++;
    $display("[FAIL] %0t watchdog expired", $time);
    results();
  end

  always @(posedge pclk) begin
    if (got_v === 1'b1) begin
      n_got++;
      check(txq.size() != 0 && got_d === txq.pop_front(), "byte to target wrong");
    end
  end

  initial begin
    presetn     = 1'b0;
    psel        = 1'b0;
    penable     = 1'b0;
    pwrite      = 1'b0;
    paddr       = 12'h000;
    pwdata      = 32'h0;
    pstrb       = 4'hF;
    link_enable = 1'b1;
    rts_en      = 1'b1;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, ufcb_pkg::ADDR_CTRL, 32'h0);
    check(rd[2:0] === ufcb_pkg::CTRL_RESET && cts_oe === 1'b0, "reset state wrong");
    apb(1'b0, ufcb_pkg::ADDR_BAUD, 32'h0);
    check(rd[15:0] === ufcb_pkg::DIV_DEFAULT, "default rate wrong");
    apb(1'b0, 12'h020, 32'h0);
    check(er === 1'b1, "unmapped access accepted");
    apb(1'b1, ufcb_pkg::ADDR_BAUD, 32'h0000FFFF);
    apb(1'b0, ufcb_pkg::ADDR_BAUD, 32'h0);
    check(rd[15:0] === ufcb_pkg::DIV_MAX, "slow rate not clamped");
    apb(1'b1, ufcb_pkg::ADDR_BAUD, 32'h00000001);
    apb(1'b0, ufcb_pkg::ADDR_BAUD, 32'h0);
    check(rd[15:0] === ufcb_pkg::DIV_MIN, "fast rate not clamped");
    apb(1'b1, ufcb_pkg::ADDR_BAUD, {16'h0, ufcb_pkg::DIV_MIN});
    apb(1'b0, ufcb_pkg::ADDR_BAUD, 32'h0);
    check(rd[15:0] === ufcb_pkg::DIV_MIN, "top rate refused");
    $display("test registers done");
    // Every mode with rts low: only gating modes hold the byte back
    for (int m = 0; m < 4; m++) begin
      apb(1'b1, ufcb_pkg::ADDR_CTRL, {29'h0, m[1:0], 1'b1});
      rts_en <= 1'b0;
      base = n_got;
      put(rnd(), 1'b1);
      repeat (CH + 100) @(posedge pclk);
      check(n_got == base + (m[1] ? 0 : 1), "rts gating wrong");
      check(cts_oe === m[0] && cts_o === m[0], "cts drive wrong");
      rts_en <= 1'b1;
      wait_got(base + 1);
    end
    $display("test modes done");
    // Fill the transmit buffer while the target holds off
    apb(1'b1, ufcb_pkg::ADDR_CTRL, 32'h5);
    rts_en <= 1'b0;
    base = n_got;
    for (int i = 0; i < 9; i++) put(rnd(), i < 8);
    rts_en <= 1'b1;
    for (int k = 0; k < 500 && txd !== 1'b0; k++) @(posedge pclk);
    rts_en <= 1'b0;
    repeat (2 * CH) @(posedge pclk);
    check(n_got == base + 1, "rts drop mishandled");
    rts_en <= 1'b1;
    wait_got(base + 8);
    $display("test fill done");
    apb(1'b1, ufcb_pkg::ADDR_CTRL, 32'h1);
    link_enable <= 1'b0;
    base = n_got;
    put(rnd(), 1'b1);
    repeat (CH + 100) @(posedge pclk);
    check(n_got == base, "sent while disabled");
    link_enable <= 1'b1;
    wait_got(base + 1);
    $display("test enable done");
    // Outbound throttling: receive buffer fills, target stalls
    apb(1'b1, ufcb_pkg::ADDR_CTRL, 32'h3);
    rts_en <= 1'b0;
    base = n_got;
    put(rnd(), 1'b1);
    for (int i = 0; i < 9; i++) rxq.push_back(rnd());
    fork
      for (int i = 0; i < 9; i++) i_tgt.send(rxq[i], i);
    join_none
    wait_got(base + 1);
    for (int k = 0; k < 12 * CH && cts_o !== 1'b0; k++) @(posedge pclk);
    check(cts_o === 1'b0, "cts not dropped on full");
    repeat (2 * CH) @(posedge pclk);
    apb(1'b0, ufcb_pkg::ADDR_STATUS, 32'h0);
    check(rd[ufcb_pkg::ST_RXFULL] === 1'b1 && cts_o === 1'b0, "target not held");
    apb(1'b0, ufcb_pkg::ADDR_RXDATA, 32'h0);
    check(rd[7:0] === rxq.pop_front(), "received byte wrong");
    repeat (4) @(posedge pclk);
    check(cts_o === 1'b1, "cts not restored");
    repeat (CH + 200) @(posedge pclk);
    for (int i = 0; i < 8; i++) begin
      apb(1'b0, ufcb_pkg::ADDR_RXDATA, 32'h0);
      check(rd[7:0] === rxq.pop_front(), "received byte wrong");
    end
    apb(1'b0, ufcb_pkg::ADDR_STATUS, 32'h0);
    check(rd[ufcb_pkg::ST_RXVALID] === 1'b0, "receive buffer not empty");
    check(rd[ufcb_pkg::ST_FRAMEERR] === 1'b0, "receive error flagged");
    $display("test receive done");
    results();
  end
endmodule : ufcb_bridge_tb_top

bind ufcb_bridge ufcb_bridge_monitor i_mon (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .txd(txd), .rxd(rxd), .cts_o(cts_o), .cts_oe(cts_oe),
  .rts_i(rts_i), .link_enable(link_enable)
);
`default_nettype wire
